// file: hw/dspt_defs.vh
`ifndef DSPT_DEFS_VH
`define DSPT_DEFS_VH
`define DSPT_A_CTRL 8'h00
`define DSPT_A_CMPA 8'h04
`define DSPT_A_CMPB 8'h08
`define DSPT_A_CAPT 8'h0C
`define DSPT_A_CNT 8'h10
`define DSPT_A_FLAG 8'h14
`define DSPT_A_ACTA 8'h18
`define DSPT_A_ACTB 8'h1C
`define DSPT_TOP8 16'h00FF
`define DSPT_TOP9 16'h01FF
`define DSPT_TOP10 16'h03FF
`define DSPT_BOTTOM 16'h0000
`define DSPT_MAX 16'hFFFF
`define DSPT_M_PC8 4'h1
`define DSPT_M_PC9 4'h2
`define DSPT_M_PC10 4'h3
`define DSPT_M_PFC_CAP 4'h8
`define DSPT_M_PFC_CMP 4'h9
`define DSPT_M_PC_CAP 4'hA
`define DSPT_M_PC_CMP 4'hB
`define DSPT_COM_TOG 2'h1
`define DSPT_COM_NINV 2'h2
`define DSPT_COM_INV 2'h3
`define DSPT_PS_1 3'h1
`define DSPT_PS_8 3'h2
`define DSPT_PS_64 3'h3
`define DSPT_PS_256 3'h4
`define DSPT_PS_1024 3'h5
`define DSPT_DIV_8 10'h007
`define DSPT_DIV_64 10'h03F
`define DSPT_DIV_256 10'h0FF
`define DSPT_DIV_1024 10'h3FF
// control word fields
`define DSPT_F_MODE 3:0
`define DSPT_F_PS 6:4
`define DSPT_F_COMA 9:8
`define DSPT_F_COMB 11:10
`define DSPT_F_OEA 12
`define DSPT_F_OEB 13
`define DSPT_F_DIRA 14
`define DSPT_F_DIRB 15
// flag word bits
`define DSPT_B_OVF 0
`define DSPT_B_CFA 1
`define DSPT_B_CFB 2
`define DSPT_B_CAPF 3
`endif

// file: hw/dspt_prescaler.v
`timescale 1ns/1ns
`include "dspt_defs.vh"
module dspt_prescaler (
  input wire MCLK_IN,
  input wire RESET_IN,
  input wire [2:0] sel_in,
  output reg tick_out
);
  reg [9:0] div_q;
  reg [9:0] term;
  always @* begin
    case (sel_in)
      `DSPT_PS_8: term = `DSPT_DIV_8;
      `DSPT_PS_64: term = `DSPT_DIV_64;
      `DSPT_PS_256: term = `DSPT_DIV_256;
      `DSPT_PS_1024: term = `DSPT_DIV_1024;
      default: term = 10'h000;
    endcase
  end
  // free-running divider, so changing the factor needs no restart
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      div_q <= 10'h000;
      tick_out <= 1'b0;
    end else begin
      div_q <= div_q + 10'h001;
      tick_out <= (sel_in == `DSPT_PS_1) ||
                  ((sel_in >= `DSPT_PS_8) && (sel_in <= `DSPT_PS_1024) &&
                   ((div_q & term) == term));
    end
  end
endmodule // dspt_prescaler

// file: hw/dspt_timer.v
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`include "dspt_defs.vh"
module dspt_timer (
  input wire MCLK_IN,
  input wire RESET_IN,
  input wire [31:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire HWRITE_IN,
  input wire [2:0] HSIZE_IN,
  input wire HSEL_IN,
  input wire HREADY_IN,
  input wire [31:0] HWDATA_IN,
  output wire [31:0] HRDATA_OUT,
  output wire HREADYOUT_OUT,
  output wire HRESP_OUT,
  output reg WAVE_OUT_A_OUT,
  output reg WAVE_OUT_B_OUT,
  output reg WAVE_OE_A_OUT,
  output reg WAVE_OE_B_OUT
);
  reg [15:0] ctrl_q;
  reg [15:0] buf_a_q;
  reg [15:0] buf_b_q;
  reg [15:0] compare_reg_a_q;
  reg [15:0] compare_reg_b_q;
  reg [15:0] capture_reg_q;
  reg [15:0] count_value_q;
  reg count_down_q;
  reg [3:0] flags_q;
  reg wave_a_q;
  reg wave_b_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [31:0] rdata_q;
  wire tick;
  wire [3:0] wave_mode_sel;
  wire wave_mode_top_bit;
  wire [1:0] out_mode_a;
  wire [1:0] out_mode_b;
  wire out_enable_a;
  wire out_enable_b;
  wire pin_direction_bit_a;
  wire pin_direction_bit_b;
  reg mode_pc;
  reg mode_pfc;
  wire pwm_on;
  reg top_from_a;
  reg top_from_cap;
  reg [15:0] top_val;
  reg [15:0] mask_val;
  wire at_top;
  wire at_bottom;
  wire match_a;
  wire match_b;
  wire upd_top;
  wire upd_bottom;
  wire addr_ok;
  wire rd_req;
  wire [15:0] wr_data;
  wire step;
  wire conn_a;
  wire conn_b;
  wire clr_flags;
  reg [3:0] flag_set;
  reg [15:0] cnt_d;
  reg down_d;
  reg wave_a_d;
  reg wave_b_d;
  reg [31:0] rd_mux;

  assign wave_mode_sel = ctrl_q[`DSPT_F_MODE];
  assign wave_mode_top_bit = wave_mode_sel[3];
  assign out_mode_a = ctrl_q[`DSPT_F_COMA];
  assign out_mode_b = ctrl_q[`DSPT_F_COMB];
  assign out_enable_a = ctrl_q[`DSPT_F_OEA];
  assign out_enable_b = ctrl_q[`DSPT_F_OEB];
  assign pin_direction_bit_a = ctrl_q[`DSPT_F_DIRA];
  assign pin_direction_bit_b = ctrl_q[`DSPT_F_DIRB];

  dspt_prescaler u_presc (
    .MCLK_IN(MCLK_IN),
    .RESET_IN(RESET_IN),
    .sel_in(ctrl_q[`DSPT_F_PS]),
    .tick_out(tick)
  );

  // decode of the mode field into slope kind and TOP source flags; top_val is decoded in its own case below
  always @* begin
    mode_pc = 1'b0;
    mode_pfc = 1'b0;
    top_from_a = 1'b0;
    top_from_cap = 1'b0;
    case (wave_mode_sel)
      `DSPT_M_PC8, `DSPT_M_PC9, `DSPT_M_PC10: mode_pc = 1'b1;
      `DSPT_M_PC_CAP: begin
        mode_pc = 1'b1;
        top_from_cap = 1'b1;
      end
      `DSPT_M_PC_CMP: begin
        mode_pc = 1'b1;
        top_from_a = 1'b1;
      end
      `DSPT_M_PFC_CAP: begin
        mode_pfc = 1'b1;
        top_from_cap = 1'b1;
      end
      `DSPT_M_PFC_CMP: begin
        mode_pfc = 1'b1;
        top_from_a = 1'b1;
      end
      default: mode_pc = 1'b0;
    endcase
  end
  assign pwm_on = mode_pc | mode_pfc;
  // channel A may also connect through the toggle setting; B cannot
  assign conn_a = out_mode_a[1] || (out_mode_a[0] && wave_mode_top_bit);
  assign conn_b = out_mode_b[1];

  always @* begin
    case (wave_mode_sel)
      `DSPT_M_PC8: top_val = `DSPT_TOP8;
      `DSPT_M_PC9: top_val = `DSPT_TOP9;
      `DSPT_M_PC10: top_val = `DSPT_TOP10;
      `DSPT_M_PC_CAP: top_val = capture_reg_q;
      `DSPT_M_PC_CMP: top_val = compare_reg_a_q;
      `DSPT_M_PFC_CAP: top_val = capture_reg_q;
      `DSPT_M_PFC_CMP: top_val = compare_reg_a_q;
      default: top_val = `DSPT_MAX;
    endcase
  end

  // fixed-TOP modes clip compare writes to the TOP width
  always @* begin
    case (wave_mode_sel)
      `DSPT_M_PC8: mask_val = `DSPT_TOP8;
      `DSPT_M_PC9: mask_val = `DSPT_TOP9;
      `DSPT_M_PC10: mask_val = `DSPT_TOP10;
      default: mask_val = `DSPT_MAX;
    endcase
  end

  assign at_top = (count_value_q == top_val);
  assign at_bottom = (count_value_q == `DSPT_BOTTOM);
  assign match_a = (count_value_q == compare_reg_a_q);
  assign match_b = (count_value_q == compare_reg_b_q);
  // events act on the tick that starts after the counter lands on the value
  // timer only runs in the seven dual-slope modes (phase-correct and phase-and-frequency-correct)
  assign step = tick && pwm_on;
  assign upd_top = step && at_top && !count_down_q;
  assign upd_bottom = step && at_bottom && count_down_q;

  // counter
  always @* begin
    cnt_d = count_value_q;
    down_d = count_down_q;
    if (step) begin
      if (!count_down_q) begin
        if (at_top) begin
          down_d = 1'b1;
          cnt_d = count_value_q - 16'h0001;
        end else begin
          cnt_d = count_value_q + 16'h0001;
        end
      end else begin
        if (at_bottom) begin
          down_d = 1'b0;
          cnt_d = count_value_q + 16'h0001;
        end else begin
          cnt_d = count_value_q - 16'h0001;
        end
      end
    end
  end

  // output compare logic; zero and TOP are turning points, resolved to steady levels
  function wave_step;
    input cur;
    input [1:0] com;
    input match;
    input down;
    input top;
    input bottom;
    input tog_ok;
    begin
      wave_step = cur;
      if (match) begin
        case (com)
          `DSPT_COM_TOG: begin
            if (tog_ok)
              wave_step = ~cur;
          end
          `DSPT_COM_NINV: begin
            if (bottom)
              wave_step = 1'b0;
            else if (top)
              wave_step = 1'b1;
            else
              wave_step = down;
          end
          `DSPT_COM_INV: begin
            if (bottom)
              wave_step = 1'b1;
            else if (top)
              wave_step = 1'b0;
            else
              wave_step = ~down;
          end
          default: wave_step = cur;
        endcase
      end
    end
  endfunction

  always @* begin
    wave_a_d = wave_a_q;
    wave_b_d = wave_b_q;
    if (step) begin
      wave_a_d = wave_step(wave_a_q, out_mode_a, match_a, count_down_q, at_top, at_bottom,
                           wave_mode_top_bit);
      // channel B has no toggle function
      wave_b_d = wave_step(wave_b_q, out_mode_b, match_b, count_down_q, at_top, at_bottom,
                           1'b0);
    end
  end

  always @* begin
    flag_set = 4'h0;
    if (step) begin
      flag_set[`DSPT_B_CFA] = match_a;
      flag_set[`DSPT_B_CFB] = match_b;
      if (upd_bottom)
        flag_set[`DSPT_B_OVF] = 1'b1;
      if (upd_top && top_from_a)
        flag_set[`DSPT_B_CFA] = 1'b1;
      if (upd_top && top_from_cap)
        flag_set[`DSPT_B_CAPF] = 1'b1;
    end
  end

  // AHB-Lite slave, zero wait states
  assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign rd_req = addr_ok && !HWRITE_IN;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = rdata_q;
  assign wr_data = HWDATA_IN[15:0];
  assign clr_flags = wr_pend_q && (wr_addr_q == `DSPT_A_FLAG);

  // registers are 16 bits wide, flags 4 bits; the upper half of the bus word reads zero
  function [31:0] word16;
    input [15:0] val;
    begin
      word16 = {16'h0000, val};
    end
  endfunction

  always @* begin
    case (HADDR_IN[7:0])
      `DSPT_A_CTRL: rd_mux = word16(ctrl_q);
      `DSPT_A_CMPA: rd_mux = word16(buf_a_q);
      `DSPT_A_CMPB: rd_mux = word16(buf_b_q);
      `DSPT_A_CAPT: rd_mux = word16(capture_reg_q);
      `DSPT_A_CNT: rd_mux = word16(count_value_q);
      `DSPT_A_FLAG: rd_mux = {28'h0000000, flags_q};
      `DSPT_A_ACTA: rd_mux = word16(compare_reg_a_q);
      `DSPT_A_ACTB: rd_mux = word16(compare_reg_b_q);
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      ctrl_q <= 16'h0000;
      buf_a_q <= 16'h0000;
      buf_b_q <= 16'h0000;
      compare_reg_a_q <= 16'h0000;
      compare_reg_b_q <= 16'h0000;
      capture_reg_q <= 16'h0000;
      count_value_q <= 16'h0000;
      count_down_q <= 1'b0;
      flags_q <= 4'h0;
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
      WAVE_OUT_A_OUT <= 1'b0;
      WAVE_OUT_B_OUT <= 1'b0;
      WAVE_OE_A_OUT <= 1'b0;
      WAVE_OE_B_OUT <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && HWRITE_IN;
      wr_addr_q <= HADDR_IN[7:0];
      if (rd_req)
        rdata_q <= rd_mux;
      count_value_q <= cnt_d;
      count_down_q <= down_d;
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
      // hardware set wins over a same-cycle write-one clear
      if (clr_flags)
        flags_q <= (flags_q & ~HWDATA_IN[3:0]) | flag_set;
      else
        flags_q <= flags_q | flag_set;
      if ((mode_pc && upd_top) || (mode_pfc && upd_bottom)) begin
        compare_reg_a_q <= buf_a_q;
        compare_reg_b_q <= buf_b_q;
      end
      if (wr_pend_q) begin
        case (wr_addr_q)
          `DSPT_A_CTRL: ctrl_q <= wr_data;
          `DSPT_A_CMPA: buf_a_q <= wr_data & mask_val;
          `DSPT_A_CMPB: buf_b_q <= wr_data & mask_val;
          `DSPT_A_CAPT: capture_reg_q <= wr_data;
          `DSPT_A_CNT: count_value_q <= wr_data;
          default: ;
        endcase
      end
      WAVE_OUT_A_OUT <= wave_a_q;
      WAVE_OUT_B_OUT <= wave_b_q;
      // pin driven only when direction and enable agree and the mode connects it
      WAVE_OE_A_OUT <= pin_direction_bit_a && out_enable_a && pwm_on && conn_a;
      WAVE_OE_B_OUT <= pin_direction_bit_b && out_enable_b && pwm_on && conn_b;
    end
  end
endmodule // dspt_timer

// file: verification/dspt_props.sv
`timescale 1ns/1ns
module dspt_props (
  input wire MCLK_IN,
  input wire RESET_IN,
  input wire [31:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire HWRITE_IN,
  input wire HSEL_IN,
  input wire HREADY_IN,
  input wire [31:0] HWDATA_IN,
  input wire [31:0] HRDATA_OUT,
  input wire HREADYOUT_OUT,
  input wire HRESP_OUT,
  input wire WAVE_OE_A_OUT,
  input wire WAVE_OE_B_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  reg ph_q;
  reg wr_q;
  reg [7:0] ad_q;
  // data phase marker, so control checks see hwdata
  always @(posedge MCLK_IN) begin
    ph_q <= HSEL_IN & HREADY_IN & HTRANS_IN[1] & ~RESET_IN;
    wr_q <= HWRITE_IN;
    ad_q <= HADDR_IN[7:0];
  end
  wire cw = ph_q & wr_q & (ad_q == 8'h00);
  wire rd = ph_q & ~wr_q;
  wire [31:0] d = HWDATA_IN;
  chk_ready_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus stalled or error response");
  chk_reset_quiet: assert property ($fell(RESET_IN) |-> !WAVE_OE_A_OUT && !WAVE_OE_B_OUT)
    else $error("pin driven right after reset");
  chk_dir_a_off: assert property (cw && !d[14] |=> ##1 !WAVE_OE_A_OUT)
    else $error("pin a driven with direction input");
  chk_en_b_off: assert property (cw && !d[13] |=> ##1 !WAVE_OE_B_OUT)
    else $error("pin b driven with enable off");
  chk_mode_a_off: assert property (cw && d[9:8] == 2'h0 |=> ##1 !WAVE_OE_A_OUT)
    else $error("pin a driven while disconnected");
  chk_tog_bit_off: assert property (cw && d[9:8] == 2'h1 && !d[3] |=> ##1 !WAVE_OE_A_OUT)
    else $error("toggle mode driven with top bit clear");
  chk_nonpwm_off: assert property (cw && d[3:0] == 4'h0 |=> ##1 !WAVE_OE_A_OUT && !WAVE_OE_B_OUT)
    else $error("pin driven outside pwm modes");
  chk_pwm_a_on: assert property (cw && d[15:8] == 8'hFE && d[3:0] == 4'hA |=> ##1 WAVE_OE_A_OUT)
    else $error("pin a not driven in pwm mode");
  chk_unmapped_zero: assert property (rd && ad_q >= 8'h20 |-> HRDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (rd |-> HRDATA_OUT[31:16] == 16'h0)
    else $error("upper read half not zero");
endmodule // dspt_props
bind dspt_timer dspt_props u_props (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .HADDR_IN(HADDR_IN),
  .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HSEL_IN(HSEL_IN), .HREADY_IN(HREADY_IN),
  .HWDATA_IN(HWDATA_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
  .HRESP_OUT(HRESP_OUT), .WAVE_OE_A_OUT(WAVE_OE_A_OUT), .WAVE_OE_B_OUT(WAVE_OE_B_OUT));

// file: verification/dspt_pins.sv
`timescale 1ns/1ns
module dspt_pins (
  input wire level_in,
  input wire oe_in,
  output wire pin_out
);
  // pulled low when undriven, so a power stage stays off
  assign pin_out = oe_in ? level_in : 1'b0;
endmodule // dspt_pins

// file: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [31:0] ha = 32'h0;
  reg [1:0] ht = 2'h0;
  reg hw = 1'b0;
  reg [31:0] hd = 32'h0;
  reg [31:0] r;
  wire [31:0] rdata;
  wire rdy, resp, wa, wb, oa, ob, pa, pb;
  integer failures = 0;
  integer n_checks = 0;
  integer cyc = 0;
  dspt_timer uut (.MCLK_IN(clk), .RESET_IN(rst), .HADDR_IN(ha), .HTRANS_IN(ht), .HWRITE_IN(hw),
    .HSIZE_IN(3'h2), .HSEL_IN(1'b1), .HREADY_IN(rdy), .HWDATA_IN(hd), .HRDATA_OUT(rdata),
    .HREADYOUT_OUT(rdy), .HRESP_OUT(resp), .WAVE_OUT_A_OUT(wa), .WAVE_OUT_B_OUT(wb),
    .WAVE_OE_A_OUT(oa), .WAVE_OE_B_OUT(ob));
  dspt_pins pin_a (.level_in(wa), .oe_in(oa), .pin_out(pa));
  dspt_pins pin_b (.level_in(wb), .oe_in(ob), .pin_out(pb));
  initial forever #50 clk = ~clk;
  task stop_test;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      stop_test;
    end
  end
  task check(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // entered just after an edge; read data lands in r
  task xfer(input w, input [7:0] a, input [31:0] dv);
    begin
      ht <= 2'h2;
      hw <= w;
      ha <= {24'h0, a};
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      ht <= 2'h0;
      hd <= dv;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      r = rdata;
    end
  endtask
  task do_reset;
    begin
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
    end
  endtask
  // prescale /8 leaves room to read every count value
  task run_seq(input [3:0] m, input [15:0] top, input [15:0] st, input [15:0] act, input [3:0] fl);
    reg [15:0] e;
    reg [15:0] last;
    reg up;
    integer n, k;
    begin
      do_reset;
      xfer(1, 8'h00, {28'h0, m});
      xfer(1, 8'h04, 32'h1);
      xfer(1, 8'h08, 32'h3);
      xfer(1, 8'h0C, {16'h0, top});
      xfer(1, 8'h10, {16'h0, st});
      xfer(1, 8'h00, {25'h0, 3'h2, m});
      e = st;
      last = st;
      up = 1'b1;
      n = 0;
      for (k = 0; k < 400 && n < 12; k++) begin
        xfer(0, 8'h10, 32'h0);
        if (r[15:0] !== last) begin
          if (up && e == top) up = 1'b0;
          else if (!up && e == 16'h0) up = 1'b1;
          e = up ? e + 16'h1 : e - 16'h1;
          check("count", {16'h0, e}, r);
          last = r[15:0];
          n = n + 1;
          // rising slope: nothing loaded before the first update point, buffer after it
          if (up && e == 16'h2) begin
            xfer(0, 8'h18, 32'h0);
            check("active_a_up", (n < 3) ? 32'h0 : 32'h1, r);
          end
          // falling slope: loaded at TOP in phase-correct, still old in frequency-correct
          if (!up && e == 16'h4) begin
            xfer(0, 8'h18, 32'h0);
            check("active_a", {16'h0, act}, r);
          end
          if (n == 2) xfer(1, 8'h14, 32'hF);
        end
      end
      check("changes", 32'd12, n);
      xfer(0, 8'h14, 32'h0);
      check("flags", {28'h0, fl}, r);
    end
  endtask
  task run_pwm(input [15:0] c, input [15:0] ctl, input integer ea, input integer eb);
    integer k, na, nb;
    begin
      xfer(1, 8'h04, {16'h0, c});
      xfer(1, 8'h08, {16'h0, c});
      xfer(1, 8'h00, {16'h0, ctl});
      repeat (40) @(posedge clk);
      na = 0;
      nb = 0;
      for (k = 0; k < 100; k++) begin
        @(posedge clk);
        na = na + pa;
        nb = nb + pb;
      end
      check("pin_a_high", ea, na);
      check("pin_b_high", eb, nb);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(0, 8'h00, 32'h0);
    check("ctrl_reset", 32'h0, r);
    xfer(1, 8'h40, 32'hFFFF);
    xfer(0, 8'h40, 32'h0);
    check("unmapped", 32'h0, r);
    xfer(1, 8'h00, 32'hD111);
    xfer(1, 8'h00, 32'hF210);
    xfer(1, 8'h00, 32'hF41A);
    run_seq(4'h1, 16'h00FF, 16'h00FD, 16'h0, 4'h0);
    xfer(1, 8'h04, 32'hFFFF);
    xfer(0, 8'h04, 32'h0);
    check("masked_a", 32'h00FF, r);
    run_seq(4'hA, 16'h5, 16'h0, 16'h1, 4'hF);
    run_seq(4'h8, 16'h5, 16'h0, 16'h0, 4'hF);
    do_reset;
    xfer(1, 8'h0C, 32'h5);
    run_pwm(16'h2, 16'hFE1A, 40, 60);
    run_pwm(16'h0, 16'hFE1A, 0, 100);
    run_pwm(16'h5, 16'hFE1A, 100, 0);
    run_pwm(16'h5, 16'hBE1A, 0, 0);
    run_pwm(16'h5, 16'hFD1A, 50, 0);
    run_pwm(16'h2, 16'hFE18, 40, 60);
    stop_test;
  end
endmodule // testbench
